// ---- dsr_host.sv ----
`timescale 1ns/1ns
`default_nettype none
module dsr_host (
    // Link clock and answer
    input wire logic i_link_clk,
    input wire logic i_busy,
    input wire logic i_ack,
    input wire logic [7:0] i_rdata,
    // Request
    output logic o_req_valid,
    output logic [1:0] o_req_kind,
    output logic [3:0] o_req_index,
    output logic [7:0] o_req_data
);
    initial begin
        o_req_valid = 1'b0;
        o_req_kind = 2'b00;
        o_req_index = 4'h0;
        o_req_data = 8'h00;
    end

    // Request held until ack or 60 link cycles; released index and data lines carry inverted values
    task automatic access(input logic [1:0] kind, input logic [3:0] idx,
                          input logic [7:0] data, output logic [7:0] rdata);
        int n;
        n = 0;
        @(posedge i_link_clk);
        o_req_valid <= 1'b1;
        o_req_kind <= kind;
        o_req_index <= idx;
        o_req_data <= data;
        do begin
            @(posedge i_link_clk);
            n++;
        end while (i_ack !== 1'b1 && n < 60);
        rdata = i_rdata;
        o_req_valid <= 1'b0;
        o_req_index <= ~idx;
        o_req_data <= ~data;
    endtask : access
endmodule : dsr_host
`default_nettype wire

// ---- dsr_map.svh ----
`ifndef DSR_MAP_SVH
`define DSR_MAP_SVH
`define DSR_IDX_STATUS 4'h0
`define DSR_IDX_SECONDS 4'h1
`define DSR_IDX_HUNDREDTHS 4'h2
`define DSR_IDX_PERIODIC 4'h5
`define DSR_CTL_TERM 0
`define DSR_CTL_EEPROM 1
`define DSR_CTL_MON_SEL 2
`define DSR_CTL_RX_ON 3
`define DSR_CTL_DEC_ON 4
`define DSR_CTL_MASK_OOR 5
`define DSR_CTL_MASK_MON 6
`define DSR_CTL_MASK_PER 7
`define DSR_ST_CALL 0
`define DSR_ST_CALL_HI 1
`define DSR_ST_DATA 2
`define DSR_ST_EQUAL 3
`define DSR_ST_ALERT 4
`define DSR_ST_OOR 5
`define DSR_ST_MON 6
`define DSR_ST_PER 7
`define DSR_CTL_RESET 8'h00
`define DSR_STATUS_RESET 8'h00
`define DSR_SEC_MAX 6'h3B
`define DSR_HUND_MAX 7'h63
`define DSR_HUND_HALF 7'h31
`define DSR_HALT_TICKS 8'hFF
`define DSR_REF_STEP 7'h20
`define DSR_REF_SPAN 7'h4B
`define DSR_CLK_NS 4
`define DSR_TICK_NS 10000000
`define DSR_TICK_CYC (`DSR_TICK_NS / `DSR_CLK_NS)
`endif

// ---- dsr_pkg.sv ----
package dsr_pkg;
    typedef enum logic [1:0] {
        KIND_WRITE = 2'b00,
        KIND_READ = 2'b01,
        KIND_READ_END = 2'b10
    } dsr_kind_e;

    typedef enum logic [0:0] {
        RD_IDLE = 1'b0,
        RD_STATUS = 1'b1
    } dsr_rd_e;

    typedef enum logic [1:0] {
        REF_32K = 2'b00,
        REF_50HZ = 2'b01,
        REF_2HZ = 2'b10,
        REF_MINUTE = 2'b11
    } dsr_ref_e;

    typedef struct packed {
        dsr_kind_e kind;
        logic [3:0] index;
        logic [7:0] data;
    } dsr_req_s;

    typedef struct packed {
        dsr_req_s req;
        logic req_tgl;
        logic busy;
        logic ack_s1;
        logic ack_s2;
        logic ack_seen;
        logic ack;
        logic [7:0] rdata;
    } dsr_link_s;

    typedef struct packed {
        dsr_rd_e rd;
        logic tgl_s1;
        logic tgl_s2;
        logic tgl_seen;
        logic ack_tgl;
        logic bat_s1;
        logic bat_s2;
        logic don_s1;
        logic don_s2;
        logic [7:0] rdata;
        logic [7:0] status;
        logic [7:0] pend;
        logic [7:0] control;
        logic [5:0] seconds;
        logic [6:0] hundredths;
        logic [21:0] tick_cnt;
        logic [7:0] modulus;
        logic [7:0] count;
        logic [7:0] halt;
        logic oor_cond;
        logic rxe_q;
        logic defer;
        logic irq;
        logic reassert;
        logic [6:0] osc_acc;
        logic sq50;
        logic ref_out;
        logic rxe_out;
        logic roe_out;
        logic dec_on;
    } dsr_sys_s;
endpackage : dsr_pkg

// ---- dsr_top.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "dsr_map.svh"
module dsr_top #(
    parameter int TICK_CYC = `DSR_TICK_CYC
) (
    // Clocks and reset
    input wire logic i_sys_clk,
    input wire logic i_link_clk,
    input wire logic i_rstn,
    // Register access, link clock domain
    input wire logic i_req_valid,
    input wire logic [1:0] i_req_kind,
    input wire logic [3:0] i_req_index,
    input wire logic [7:0] i_req_data,
    output logic o_busy,
    output logic o_ack,
    output logic [7:0] o_rdata,
    // Decoder events, system clock domain
    input wire logic i_call_start,
    input wire logic i_call_data,
    input wire logic i_ptrs_equal_evt,
    input wire logic i_ptrs_equal,
    input wire logic i_buf_full,
    input wire logic i_second_call_pending,
    input wire logic i_alert_timeout,
    input wire logic i_fade_enter,
    input wire logic i_sync_found,
    input wire logic i_term_done,
    input wire logic i_call_received,
    input wire logic i_rx_enable_req,
    input wire logic i_osc_enable_req,
    input wire logic i_osc_tick,
    input wire logic [1:0] i_ref_sel,
    // Pins
    input wire logic i_battery_low_in,
    input wire logic i_decoder_on_pin,
    // Outputs
    output logic o_irq,
    output logic o_receiver_enable_out,
    output logic o_oscillator_enable_out,
    output logic o_decoder_on,
    output logic o_force_term,
    output logic o_eeprom_prog_en,
    output logic o_ref_out
);
    dsr_pkg::dsr_link_s l_r;
    dsr_pkg::dsr_link_s l_nxt;
    dsr_pkg::dsr_sys_s s_r;
    dsr_pkg::dsr_sys_s s_nxt;

    localparam logic [21:0] TICK_LAST = 22'(TICK_CYC - 1);

    function automatic logic [7:0] read_mux(input dsr_pkg::dsr_sys_s st, input logic [3:0] idx);
        logic [7:0] v;
        v = 8'h00;
        if (idx == `DSR_IDX_STATUS) begin
            v = st.status;
        end else if (idx == `DSR_IDX_SECONDS) begin
            v = {2'b00, st.seconds};
        end else if (idx == `DSR_IDX_HUNDREDTHS) begin
            v = {1'b0, st.hundredths};
        end else if (idx == `DSR_IDX_PERIODIC) begin
            v = st.count;
        end
        return v;
    endfunction : read_mux

    // Link side: hold one request, hand it over by toggle, wait for the answer toggle
    always_comb begin
        l_nxt = l_r;
        l_nxt.ack = 1'b0;
        l_nxt.ack_s1 = s_r.ack_tgl;
        l_nxt.ack_s2 = l_r.ack_s1;
        if (l_r.ack_s2 != l_r.ack_seen) begin
            l_nxt.ack_seen = l_r.ack_s2;
            l_nxt.rdata = s_r.rdata;
            l_nxt.ack = 1'b1;
            l_nxt.busy = 1'b0;
        end else if (i_req_valid && !l_r.busy && !l_r.ack) begin
            l_nxt.req.kind = dsr_pkg::dsr_kind_e'(i_req_kind);
            l_nxt.req.index = i_req_index;
            l_nxt.req.data = i_req_data;
            l_nxt.req_tgl = ~l_r.req_tgl;
            l_nxt.busy = 1'b1;
        end
    end

    always_ff @(posedge i_link_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            l_r <= '0;
        end else begin
            l_r <= l_nxt;
        end
    end

    // Decoder side
    logic new_req;
    logic tick;
    logic rx_fall;
    logic mon_src;
    logic mon_chg;
    logic oor_new;
    logic oor_chg;
    logic per_hit;
    logic min_pulse;
    logic trig;
    logic [7:0] ev;
    logic [7:0] clr;
    logic [7:0] cnt_inc;

    always_comb begin
        s_nxt = s_r;
        new_req = s_r.tgl_s2 != s_r.tgl_seen;
        clr = 8'h00;
        s_nxt.tgl_s1 = l_r.req_tgl;
        s_nxt.tgl_s2 = s_r.tgl_s1;
        s_nxt.tgl_seen = s_r.tgl_s2;
        s_nxt.bat_s1 = i_battery_low_in;
        s_nxt.bat_s2 = s_r.bat_s1;
        s_nxt.don_s1 = i_decoder_on_pin;
        s_nxt.don_s2 = s_r.don_s1;

        // Hundredths time base and real-time clock
        tick = s_r.tick_cnt == TICK_LAST;
        s_nxt.tick_cnt = tick ? 22'h00_0000 : s_r.tick_cnt + 22'h00_0001;
        min_pulse = 1'b0;
        if (tick) begin
            if (s_r.hundredths == `DSR_HUND_MAX) begin
                s_nxt.hundredths = 7'h00;
                if (s_r.seconds == `DSR_SEC_MAX) begin
                    s_nxt.seconds = 6'h00;
                    min_pulse = 1'b1;
                end else begin
                    s_nxt.seconds = s_r.seconds + 6'h01;
                end
            end else begin
                s_nxt.hundredths = s_r.hundredths + 7'h01;
            end
        end

        // Receiver and oscillator control
        s_nxt.rxe_out = s_r.control[`DSR_CTL_RX_ON] | i_rx_enable_req;
        s_nxt.roe_out = s_r.control[`DSR_CTL_RX_ON] | i_osc_enable_req;
        s_nxt.dec_on = s_r.control[`DSR_CTL_DEC_ON] | s_r.don_s2;
        s_nxt.rxe_q = s_r.rxe_out;
        rx_fall = s_r.rxe_q && !s_r.rxe_out;

        // Out-of-range condition, entry wins over recovery
        if (i_fade_enter) begin
            s_nxt.oor_cond = 1'b1;
        end else if (i_sync_found) begin
            s_nxt.oor_cond = 1'b0;
        end

        // Periodic counter
        per_hit = 1'b0;
        cnt_inc = s_r.count + 8'h01;
        if (tick) begin
            if (s_r.modulus != 8'h00) begin
                if (cnt_inc == s_r.modulus) begin
                    per_hit = 1'b1;
                    s_nxt.count = 8'h00;
                end else begin
                    s_nxt.count = cnt_inc;
                end
            end else if (s_r.halt != 8'h00) begin
                s_nxt.count = cnt_inc;
                s_nxt.halt = s_r.halt - 8'h01;
            end
        end
        if (i_call_received) begin
            s_nxt.modulus = 8'h00;
            s_nxt.count = 8'h00;
            s_nxt.halt = `DSR_HALT_TICKS;
        end

        // Level bits of status
        oor_new = rx_fall ? s_r.oor_cond : s_r.status[`DSR_ST_OOR];
        oor_chg = oor_new != s_r.status[`DSR_ST_OOR];
        mon_src = s_r.control[`DSR_CTL_MON_SEL] ? s_r.rxe_out : s_r.bat_s2;
        mon_chg = mon_src != s_r.status[`DSR_ST_MON];
        s_nxt.status[`DSR_ST_OOR] = oor_new;
        s_nxt.status[`DSR_ST_MON] = mon_src;

        // Sticky events; D1 is never set so the call field stays 00 or 01
        ev = 8'h00;
        ev[`DSR_ST_CALL] = i_call_start;
        ev[`DSR_ST_DATA] = i_call_data | i_buf_full;
        ev[`DSR_ST_EQUAL] = i_ptrs_equal_evt | i_buf_full;
        ev[`DSR_ST_ALERT] = i_alert_timeout;
        ev[`DSR_ST_PER] = per_hit;
        if (s_r.rd == dsr_pkg::RD_STATUS) begin
            s_nxt.pend = s_r.pend | ev;
        end else if (i_call_start && s_r.status[`DSR_ST_CALL]) begin
            s_nxt.pend = (s_r.pend & ~8'h03) | ev;
            s_nxt.status = s_nxt.status | (ev & ~8'h01);
        end else begin
            s_nxt.status = s_nxt.status | ev;
        end

        // Interrupt sources; deferred ones wait for the receiver to turn off
        trig = i_ptrs_equal_evt | i_buf_full | i_alert_timeout
            | (per_hit & ~s_r.control[`DSR_CTL_MASK_PER])
            | (mon_chg & s_r.control[`DSR_CTL_MON_SEL] & ~s_r.control[`DSR_CTL_MASK_MON]);
        if (i_call_data
            || (oor_chg && !s_r.control[`DSR_CTL_MASK_OOR])
            || (mon_chg && !s_r.control[`DSR_CTL_MON_SEL]
                && !s_r.control[`DSR_CTL_MASK_MON])) begin
            s_nxt.defer = 1'b1;
        end
        if (s_r.defer && !s_r.rxe_out && s_r.rd == dsr_pkg::RD_IDLE) begin
            trig = 1'b1;
            s_nxt.defer = 1'b0;
        end
        s_nxt.reassert = 1'b0;
        if (s_r.reassert || (trig && s_r.rd == dsr_pkg::RD_IDLE)) begin
            s_nxt.irq = 1'b1;
        end
        // Self-clearing termination request
        if (i_term_done) begin
            s_nxt.control[`DSR_CTL_TERM] = 1'b0;
        end

        // Register requests from the link
        if (new_req) begin
            s_nxt.ack_tgl = ~s_r.ack_tgl;
            if (l_r.req.kind == dsr_pkg::KIND_WRITE) begin
                if (l_r.req.index == `DSR_IDX_STATUS) begin
                    s_nxt.control = l_r.req.data;
                end else if (l_r.req.index == `DSR_IDX_SECONDS) begin
                    s_nxt.seconds = l_r.req.data[5:0];
                end else if (l_r.req.index == `DSR_IDX_HUNDREDTHS) begin
                    s_nxt.hundredths = l_r.req.data[6:0];
                end else if (l_r.req.index == `DSR_IDX_PERIODIC) begin
                    s_nxt.modulus = l_r.req.data;
                    if (l_r.req.data == 8'h00) begin
                        s_nxt.halt = `DSR_HALT_TICKS;
                    end
                end
            end else if (l_r.req.kind == dsr_pkg::KIND_READ) begin
                s_nxt.rdata = read_mux(s_r, l_r.req.index);
                if (l_r.req.index == `DSR_IDX_STATUS) begin
                    s_nxt.rd = dsr_pkg::RD_STATUS;
                end
            end else if (s_r.rd == dsr_pkg::RD_STATUS) begin
                clr = 8'h00;
                clr[`DSR_ST_EQUAL] = 1'b1;
                clr[`DSR_ST_ALERT] = 1'b1;
                clr[`DSR_ST_PER] = 1'b1;
                clr[`DSR_ST_CALL] = !i_second_call_pending;
                clr[`DSR_ST_CALL_HI] = !i_second_call_pending;
                clr[`DSR_ST_DATA] = i_ptrs_equal;
                s_nxt.status = (s_nxt.status & ~clr) | s_nxt.pend;
                s_nxt.pend = 8'h00;
                s_nxt.irq = 1'b0;
                s_nxt.reassert = s_nxt.pend != 8'h00 || s_r.pend != 8'h00 || ev != 8'h00;
                s_nxt.rd = dsr_pkg::RD_IDLE;
            end
        end

        // Reference pulse output
        s_nxt.ref_out = 1'b0;
        if (i_osc_tick) begin
            if (s_r.osc_acc + `DSR_REF_STEP >= `DSR_REF_SPAN) begin
                s_nxt.osc_acc = s_r.osc_acc + `DSR_REF_STEP - `DSR_REF_SPAN;
            end else begin
                s_nxt.osc_acc = s_r.osc_acc + `DSR_REF_STEP;
            end
        end
        if (tick) begin
            s_nxt.sq50 = ~s_r.sq50;
        end
        case (dsr_pkg::dsr_ref_e'(i_ref_sel))
            dsr_pkg::REF_32K: begin
                s_nxt.ref_out = i_osc_tick && (s_r.osc_acc + `DSR_REF_STEP >= `DSR_REF_SPAN);
            end
            dsr_pkg::REF_50HZ: begin
                s_nxt.ref_out = s_nxt.sq50;
            end
            dsr_pkg::REF_2HZ: begin
                s_nxt.ref_out = tick && (s_r.hundredths == `DSR_HUND_HALF
                    || s_r.hundredths == `DSR_HUND_MAX);
            end
            default: begin
                s_nxt.ref_out = min_pulse && !s_r.rxe_out;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_busy = l_r.busy;
    assign o_ack = l_r.ack;
    assign o_rdata = l_r.rdata;
    assign o_irq = s_r.irq;
    assign o_receiver_enable_out = s_r.rxe_out;
    assign o_oscillator_enable_out = s_r.roe_out;
    assign o_decoder_on = s_r.dec_on;
    assign o_force_term = s_r.control[`DSR_CTL_TERM];
    assign o_eeprom_prog_en = s_r.control[`DSR_CTL_EEPROM];
    assign o_ref_out = s_r.ref_out;
endmodule : dsr_top
`default_nettype wire

// ---- dsr_top_asserts.sv ----
`timescale 1ns/1ns
`default_nettype none
module dsr_top_asserts (
    // Clocks and reset
    input wire logic i_sys_clk,
    input wire logic i_link_clk,
    input wire logic i_rstn,
    // Watched ports
    input wire logic o_busy,
    input wire logic o_ack,
    input wire logic i_rx_enable_req,
    input wire logic i_osc_enable_req,
    input wire logic o_receiver_enable_out,
    input wire logic o_oscillator_enable_out,
    input wire logic i_decoder_on_pin,
    input wire logic o_decoder_on,
    input wire logic o_ref_out,
    input wire logic [1:0] i_ref_sel,
    input wire logic o_force_term,
    input wire logic i_term_done
);
    a_ack_single: assert property (@(posedge i_link_clk) disable iff (!i_rstn)
        o_ack |=> !o_ack) else $error("ack longer than one cycle");
    a_ack_frees_bus: assert property (@(posedge i_link_clk) disable iff (!i_rstn)
        o_ack |-> !o_busy) else $error("busy still high at ack");
    a_rxe_follows_req: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        i_rx_enable_req |=> o_receiver_enable_out) else $error("receiver enable missing");
    a_roe_follows_req: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        i_osc_enable_req |=> o_oscillator_enable_out) else $error("oscillator enable missing");
    a_pin_turns_on: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        i_decoder_on_pin [*5] |-> o_decoder_on) else $error("decoder not on");
    a_ref_one_cycle: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        $rose(o_ref_out) && i_ref_sel != dsr_pkg::REF_50HZ |=> !o_ref_out)
        else $error("reference pulse too wide");
    a_minute_held_off: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        i_ref_sel == dsr_pkg::REF_MINUTE && o_receiver_enable_out
        && $past(o_receiver_enable_out) |-> !o_ref_out)
        else $error("minute pulse while receiver on");
    a_term_self_clear: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        o_force_term && i_term_done |-> ##[1:2] !o_force_term)
        else $error("forced termination not cleared");
endmodule : dsr_top_asserts
`default_nettype wire

bind dsr_top dsr_top_asserts chk (.i_sys_clk, .i_link_clk, .i_rstn, .o_busy, .o_ack,
    .i_rx_enable_req, .i_osc_enable_req, .o_receiver_enable_out, .o_oscillator_enable_out,
    .i_decoder_on_pin, .o_decoder_on, .o_ref_out, .i_ref_sel, .o_force_term, .i_term_done);

// ---- dsr_top_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module dsr_top_tb;
    localparam int TICK = 1000;
    logic clk, lclk, rstn, valid, busy, ack, irq, receiver_enable_out, oscillator_enable_out, decoder_on_pin, term, eep, ref_o;
    logic rx_req, don_pin, ptrs_eq;
    logic ref_q = 1'b0;
    logic [1:0] kind, ref_sel;
    logic [3:0] idx;
    logic [7:0] wdata, rdata, d;
    logic [8:0] ev;
    int mismatches, compares, base;
    int cyc = 0;
    int refcnt = 0;
    logic [7:0] ctl_val [5] = '{8'h02, 8'h08, 8'h10, 8'h00, 8'h01};
    logic [7:0] ctl_exp [5] = '{8'h08, 8'h06, 8'h01, 8'h00, 8'h10};
    logic [7:0] ev_exp [4] = '{8'h04, 8'h08, 8'h0C, 8'h10};

    dsr_top #(.TICK_CYC(TICK)) uut (.i_sys_clk(clk), .i_link_clk(lclk), .i_rstn(rstn),
        .i_req_valid(valid), .i_req_kind(kind), .i_req_index(idx), .i_req_data(wdata),
        .o_busy(busy), .o_ack(ack), .o_rdata(rdata), .i_call_start(ev[0]),
        .i_call_data(ev[1]), .i_ptrs_equal_evt(ev[2]), .i_ptrs_equal(ptrs_eq),
        .i_buf_full(ev[3]), .i_second_call_pending(1'b0), .i_alert_timeout(ev[4]),
        .i_fade_enter(ev[5]), .i_sync_found(ev[6]), .i_term_done(ev[7]),
        .i_call_received(1'b0), .i_rx_enable_req(rx_req), .i_osc_enable_req(rx_req),
        .i_osc_tick(ev[8]), .i_ref_sel(ref_sel), .i_battery_low_in(1'b0),
        .i_decoder_on_pin(don_pin), .o_irq(irq), .o_receiver_enable_out(receiver_enable_out),
        .o_oscillator_enable_out(oscillator_enable_out), .o_decoder_on(decoder_on_pin), .o_force_term(term),
        .o_eeprom_prog_en(eep), .o_ref_out(ref_o));

    dsr_host host (.i_link_clk(lclk), .i_busy(busy), .i_ack(ack), .i_rdata(rdata),
        .o_req_valid(valid), .o_req_kind(kind), .o_req_index(idx), .o_req_data(wdata));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        lclk = 1'b0;
        #37;
        forever #80 lclk = ~lclk;
    end

    always @(posedge clk) begin
        ref_q <= ref_o;
        if (ref_o && !ref_q) begin
            refcnt <= refcnt + 1;
        end
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            mismatches++;
            print_verdict();
        end
    end

    task pulse(input int b);
        @(posedge clk);
        ev[b] <= 1'b1;
        @(posedge clk);
        ev[b] <= 1'b0;
    endtask : pulse

    task automatic wr(input logic [3:0] i, input logic [7:0] v);
        logic [7:0] x;
        host.access(dsr_pkg::KIND_WRITE, i, v, x);
    endtask : wr

    task automatic rd(input logic [3:0] i, output logic [7:0] v);
        host.access(dsr_pkg::KIND_READ, i, 8'h00, v);
    endtask : rd

    task automatic read_end();
        logic [7:0] x;
        host.access(dsr_pkg::KIND_READ_END, 4'h0, 8'h00, x);
    endtask : read_end

    task automatic status_rd(output logic [7:0] v);
        rd(4'h0, v);
        read_end();
    endtask : status_rd

    task automatic rx_cycle();
        @(posedge clk);
        rx_req <= 1'b1;
        repeat (4) @(posedge clk);
        rx_req <= 1'b0;
        repeat (8) @(posedge clk);
    endtask : rx_cycle

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic print_verdict();
        $display("Counts: compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict

    initial begin
        rstn = 1'b0;
        rx_req = 1'b0;
        don_pin = 1'b0;
        ptrs_eq = 1'b1;
        ev = '0;
        ref_sel = dsr_pkg::REF_32K;
        mismatches = 0;
        compares = 0;
        repeat (8) @(posedge clk);
        repeat (2) @(posedge lclk);
        @(posedge clk) rstn <= 1'b1;
        status_rd(d);
        chk("status", 8'h00, d);
        rd(4'hB, d);
        chk("unmapped", 8'h00, d);
        for (int i = 0; i < 5; i++) begin
            wr(4'h0, ctl_val[i]);
            repeat (4) @(posedge clk);
            chk("control outputs", ctl_exp[i], {3'b000, term, eep, receiver_enable_out, oscillator_enable_out, decoder_on_pin});
        end
        pulse(7);
        repeat (4) @(posedge clk);
        chk("force term", 8'h00, {7'h00, term});
        don_pin <= 1'b1;
        repeat (8) @(posedge clk);
        chk("decoder on", 8'h01, {7'h00, decoder_on_pin});
        don_pin <= 1'b0;
        $display("Test control done");
        for (int i = 0; i < 4; i++) begin
            pulse(i + 1);
            repeat (6) @(posedge clk);
            chk("irq", 8'h01, {7'h00, irq});
            status_rd(d);
            chk("status", ev_exp[i], d);
            chk("irq", 8'h00, {7'h00, irq});
            status_rd(d);
            chk("status", 8'h00, d);
        end
        pulse(0);
        repeat (6) @(posedge clk);
        chk("irq", 8'h00, {7'h00, irq});
        status_rd(d);
        chk("status", 8'h01, d);
        rd(4'h0, d);
        pulse(4);
        read_end();
        repeat (2) @(posedge clk);
        chk("irq", 8'h01, {7'h00, irq});
        status_rd(d);
        chk("status", 8'h10, d);
        pulse(0);
        pulse(0);
        status_rd(d);
        chk("irq", 8'h01, {7'h00, irq});
        status_rd(d);
        chk("status", 8'h01, d);
        $display("Test status done");
        pulse(5);
        rx_cycle();
        chk("irq", 8'h01, {7'h00, irq});
        status_rd(d);
        chk("status", 8'h20, d);
        status_rd(d);
        chk("status", 8'h20, d);
        pulse(6);
        rx_cycle();
        chk("irq", 8'h01, {7'h00, irq});
        status_rd(d);
        chk("status", 8'h00, d);
        wr(4'h0, 8'h04);
        rx_cycle();
        chk("irq", 8'h01, {7'h00, irq});
        status_rd(d);
        chk("status", 8'h00, d);
        wr(4'h0, 8'h00);
        $display("Test range done");
        base = refcnt;
        repeat (75) begin
            pulse(8);
            repeat (2) @(posedge clk);
        end
        repeat (4) @(posedge clk);
        chk("ref pulses", 8'h20, 8'(refcnt - base));
        ref_sel <= dsr_pkg::REF_MINUTE;
        for (int r = 0; r < 2; r++) begin
            @(posedge clk);
            rx_req <= r[0];
            wr(4'h2, 8'hE0);
            wr(4'h1, 8'hFB);
            rd(4'h1, d);
            chk("seconds", 8'h3B, {2'b00, d[5:0]});
            base = refcnt;
            repeat (6 * TICK) @(posedge clk);
            rd(4'h1, d);
            chk("seconds", 8'h00, {2'b00, d[5:0]});
            chk("minute pulses", r ? 8'h00 : 8'h01, 8'(refcnt - base));
        end
        @(posedge clk);
        rx_req <= 1'b0;
        ref_sel <= dsr_pkg::REF_2HZ;
        wr(4'h2, 8'h2F);
        base = refcnt;
        repeat (4 * TICK) @(posedge clk);
        chk("half second pulses", 8'h01, 8'(refcnt - base));
        ref_sel <= dsr_pkg::REF_50HZ;
        repeat (4) @(posedge clk);
        base = refcnt;
        repeat (4 * TICK) @(posedge clk);
        chk("square edges", 8'h02, 8'(refcnt - base));
        $display("Test clock done");
        wr(4'h5, 8'h03);
        repeat (4 * TICK) @(posedge clk);
        chk("irq", 8'h01, {7'h00, irq});
        status_rd(d);
        chk("status", 8'h80, d);
        wr(4'h0, 8'h80);
        status_rd(d);
        repeat (4 * TICK) @(posedge clk);
        chk("irq", 8'h00, {7'h00, irq});
        status_rd(d);
        chk("status", 8'h80, d);
        wr(4'h5, 8'h00);
        status_rd(d);
        repeat (4 * TICK) @(posedge clk);
        status_rd(d);
        chk("status", 8'h00, d);
        $display("Test periodic done");
        print_verdict();
    end
endmodule : dsr_top_tb
`default_nettype wire
